// [core/drs_defines.vh]
// Constants for the DRAM access and refresh sequencer.
// Assumes inclusion by bare name from the core/ design files.
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

// State codes, four bits
`define DRS_ST_IDLE          4'h0
`define DRS_ST_ACCESS_BEGIN  4'h4
`define DRS_ST_ACCESS        4'h6
`define DRS_ST_READ          4'h2
`define DRS_ST_WRITE_ONE     4'he
`define DRS_ST_WRITE_TWO     4'hc
`define DRS_ST_WRITE_THREE   4'h7
`define DRS_ST_REFRESH_BEGIN 4'h8
`define DRS_ST_REFRESH       4'h9
`define DRS_ST_REFRESH_END   4'hb
`define DRS_ST_FINISH        4'h1
`define DRS_ST_POWERON       4'hf

// Cycle type codes on latched address bits 31:30
`define DRS_TYPE_LONG        2'h0
`define DRS_TYPE_HEX         2'h1
`define DRS_TYPE_QUAD        2'h2
`define DRS_TYPE_OCTA        2'h3

// Longword count reached after the last longword of each type
`define DRS_LAST_LONG        2'h1
`define DRS_LAST_QUAD        2'h2
`define DRS_LAST_FOUR        2'h0

// Input sampling
`define DRS_SYNC_STAGES      3

`endif

// [core/drs_sync.v]
// Three-stage input synchroniser with agreement filter, one per bit.
// Assumes inputs are asynchronous to mclk_i; output is registered.
`timescale 1ns/10ps
`default_nettype none

module drs_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk_i,  // System clock
    input  wire             rst_i,   // Synchronous reset, high
    input  wire [WIDTH-1:0] async_i, // Raw pin levels
    output wire [WIDTH-1:0] sync_o   // Filtered levels
);

genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
        reg s1_q;
        reg s2_q;
        reg s3_q;
        reg val_q;
        always @(posedge mclk_i)
        begin
            if (rst_i)
            begin
                s1_q  <= 1'b0;
                s2_q  <= 1'b0;
                s3_q  <= 1'b0;
                val_q <= 1'b0;
            end
            else
            begin
                s1_q <= async_i[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
                // Change counts once stages two and three agree
                if (s2_q == s3_q)
                    val_q <= s3_q;
            end
        end
        assign sync_o[g] = val_q;
    end
endgenerate

endmodule // drs_sync

`default_nettype wire

// [core/drs_burst.v]
// Burst completion terms from cycle type and longword count.
// Assumes the count already holds the value after the last advance.
`timescale 1ns/10ps
`default_nettype none
`include "drs_defines.vh"

module drs_burst (
    input  wire [1:0] cycle_type_i, // Latched address bits 31:30
    input  wire [1:0] count_i,      // Fed-back inversion bits {hi,lo}
    output wire       term_a_o,     // Longword done
    output wire       term_b_o,     // Quadword done
    output wire       term_c_o,     // Hexword group done
    output wire       term_d_o      // Octaword group done
);

// Each term: type matches and the count reached its last value
assign term_a_o = (cycle_type_i == `DRS_TYPE_LONG) &&
                  (count_i == `DRS_LAST_LONG);
assign term_b_o = (cycle_type_i == `DRS_TYPE_QUAD) &&
                  (count_i == `DRS_LAST_QUAD);
assign term_c_o = (cycle_type_i == `DRS_TYPE_HEX) &&
                  (count_i == `DRS_LAST_FOUR);
assign term_d_o = (cycle_type_i == `DRS_TYPE_OCTA) &&
                  (count_i == `DRS_LAST_FOUR);

endmodule // drs_burst

`default_nettype wire

// [core/drs_sequencer.v]
// DRAM access and refresh sequencer: strobe timing, burst stepping,
// refresh arbitration and cycle ready.
// Assumes all processor and counter inputs are asynchronous pins;
// every state step happens on a sampled rising edge of phase A.
`timescale 1ns/10ps
`default_nettype none
`include "drs_defines.vh"

module drs_sequencer (
    input  wire       mclk_i,               // 100 MHz system clock
    input  wire       rst_i,                // Synchronous reset, high
    input  wire       phase_a_clock_i,      // Processor phase A clock
    input  wire       synced_addr_strobe_i, // Address strobe, high
    input  wire       dram_select_i,        // DRAM decode select, high
    input  wire       int_ack_active_i,     // Iack cycle running, high
    input  wire       refresh_request_i,    // Refresh counter request
    input  wire       power_reset_i,        // Power-up reset, high
    input  wire       system_reset_in_i,    // System reset, high
    input  wire       data_strobe_in_i,     // Data strobe, high
    input  wire       latched_write_i,      // High for write cycles
    input  wire       phase_p4_low_i,       // Low during phase P4
    input  wire [1:0] latched_address_i,    // Address bits 31:30
    output wire       refresh_cycle_out_o,  // Refresh cycle, high
    output wire       row_strobe_o,         // Row strobe, high
    output wire       column_strobe_enable_o, // Column enable, high
    output wire       col_addr_invert_lo_o, // Invert column bit 2
    output wire       col_addr_invert_hi_o, // Invert column bit 3
    output wire       mem_cycle_ready_o     // Cycle ready, high
);

localparam NUM_IN = 12;

// Sampled pins
wire [NUM_IN-1:0] raw_w;
wire [NUM_IN-1:0] smp_w;

assign raw_w = {phase_a_clock_i, synced_addr_strobe_i, dram_select_i,
                int_ack_active_i, refresh_request_i, power_reset_i,
                system_reset_in_i, data_strobe_in_i, latched_write_i,
                phase_p4_low_i, latched_address_i};

drs_sync #(
    .WIDTH (NUM_IN)
) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (raw_w),
    .sync_o  (smp_w)
);

wire       phase_a_clock_w    = smp_w[11];
wire       sas_w     = smp_w[10];
wire       sel_w     = smp_w[9];
wire       iack_w    = smp_w[8];
wire       refresh_request_w  = smp_w[7];
wire       pwr_w     = smp_w[6];
wire       sysrst_w  = smp_w[5];
wire       ds_w      = smp_w[4];
wire       write_w   = smp_w[3];
wire       p4_n_w    = smp_w[2];
wire [1:0] ctype_w   = smp_w[1:0];

// Phase A rising edge enable
reg phase_a_clock_prev_q;

always @(posedge mclk_i)
begin
    if (rst_i)
        phase_a_clock_prev_q <= 1'b0;
    else
        phase_a_clock_prev_q <= phase_a_clock_w;
end

wire step_w = phase_a_clock_w & ~phase_a_clock_prev_q;

// Registered state and outputs
reg [3:0] state_q;
reg [3:0] state_d;
reg       refresh_cycle_out_q;
reg       refresh_cycle_out_d;
reg       ras_q;
reg       ras_d;
reg       cas_q;
reg       cas_d;
reg       inv_lo_q;
reg       inv_lo_d;
reg       inv_hi_q;
reg       inv_hi_d;
reg       ready_q;
reg       ready_d;
reg       repeat_q;
reg       repeat_d;

// Access request term, refresh takes priority
wire access_w = sas_w & sel_w & ~iack_w & ~refresh_request_w;

// Refresh demand includes power-up warm-up
wire refresh_w = refresh_request_w | pwr_w;

// Fed-back inversion bits as a two-bit count
wire [1:0] count_w      = {inv_hi_q, inv_lo_q};
wire [1:0] count_next_w = count_w + 2'h1;

wire term_a_w;
wire term_b_w;
wire term_c_w;
wire term_d_w;

drs_burst u_burst (
    .cycle_type_i (ctype_w),
    .count_i      (count_w),
    .term_a_o     (term_a_w),
    .term_b_o     (term_b_w),
    .term_c_o     (term_c_w),
    .term_d_o     (term_d_w)
);

wire done_w = term_a_w | term_b_w | term_c_w | term_d_w;

wire p4_w = ~p4_n_w;

always @*
begin
    state_d  = state_q;
    refresh_cycle_out_d = refresh_cycle_out_q;
    ras_d    = ras_q;
    cas_d    = cas_q;
    inv_lo_d = inv_lo_q;
    inv_hi_d = inv_hi_q;
    ready_d  = ready_q;
    repeat_d = repeat_q;
    case (state_q)
        `DRS_ST_IDLE:
        begin
            if (refresh_w)
            begin
                state_d  = `DRS_ST_REFRESH_BEGIN;
                refresh_cycle_out_d = 1'b1;
                cas_d    = 1'b1;
            end
            else if (access_w)
            begin
                state_d = `DRS_ST_ACCESS_BEGIN;
                ras_d   = 1'b1;
            end
            else
            begin
                refresh_cycle_out_d = 1'b0;
                ras_d    = 1'b0;
                cas_d    = 1'b0;
                inv_lo_d = 1'b0;
                inv_hi_d = 1'b0;
                ready_d  = 1'b0;
                repeat_d = 1'b0;
            end
        end
        `DRS_ST_ACCESS_BEGIN:
        begin
            if (access_w && ds_w)
            begin
                state_d = `DRS_ST_ACCESS;
                cas_d   = 1'b1;
            end
            else if (!access_w)
                state_d = `DRS_ST_REFRESH_END;
        end
        `DRS_ST_ACCESS:
        begin
            if (p4_w && !write_w && (!repeat_q || !ds_w))
            begin
                state_d  = `DRS_ST_READ;
                ready_d  = 1'b1;
                cas_d    = 1'b0;
                inv_lo_d = count_next_w[0];
                inv_hi_d = count_next_w[1];
            end
            else if (p4_w && write_w)
            begin
                state_d  = `DRS_ST_WRITE_ONE;
                ready_d  = 1'b1;
                cas_d    = 1'b0;
                inv_lo_d = count_next_w[0];
                inv_hi_d = count_next_w[1];
            end
        end
        `DRS_ST_READ:
        begin
            if (access_w && !done_w)
            begin
                state_d  = `DRS_ST_ACCESS;
                cas_d    = 1'b1;
                ready_d  = 1'b0;
                repeat_d = 1'b1;
            end
            else if (term_d_w)
            begin
                state_d  = `DRS_ST_REFRESH;
                ras_d    = 1'b0;
                cas_d    = 1'b0;
                inv_lo_d = 1'b0;
                inv_hi_d = 1'b0;
                ready_d  = 1'b0;
                repeat_d = 1'b0;
            end
            else
            begin
                state_d  = `DRS_ST_FINISH;
                ras_d    = 1'b0;
                cas_d    = 1'b0;
                inv_lo_d = 1'b0;
                inv_hi_d = 1'b0;
                ready_d  = 1'b0;
                repeat_d = 1'b0;
            end
        end
        `DRS_ST_WRITE_ONE:
        begin
            if (access_w && !done_w)
            begin
                state_d = `DRS_ST_WRITE_TWO;
                ready_d = 1'b0;
            end
            else
            begin
                state_d  = `DRS_ST_FINISH;
                ras_d    = 1'b0;
                cas_d    = 1'b0;
                inv_lo_d = 1'b0;
                inv_hi_d = 1'b0;
                ready_d  = 1'b0;
            end
        end
        `DRS_ST_WRITE_TWO:
        begin
            if (!ds_w)
                state_d = `DRS_ST_WRITE_THREE;
        end
        `DRS_ST_WRITE_THREE:
        begin
            if (ds_w)
            begin
                state_d  = `DRS_ST_ACCESS;
                cas_d    = 1'b1;
                repeat_d = 1'b1;
            end
        end
        `DRS_ST_REFRESH_BEGIN:
        begin
            state_d = `DRS_ST_REFRESH;
            ras_d   = 1'b1;
        end
        `DRS_ST_REFRESH:
        begin
            state_d = `DRS_ST_REFRESH_END;
            cas_d   = 1'b0;
        end
        `DRS_ST_REFRESH_END:
        begin
            state_d  = `DRS_ST_FINISH;
            refresh_cycle_out_d = 1'b0;
            ras_d    = 1'b0;
        end
        `DRS_ST_FINISH:
        begin
            state_d  = `DRS_ST_IDLE;
            refresh_cycle_out_d = 1'b0;
            ras_d    = 1'b0;
            cas_d    = 1'b0;
            inv_lo_d = 1'b0;
            inv_hi_d = 1'b0;
            ready_d  = 1'b0;
            repeat_d = 1'b0;
        end
        default:
            state_d = `DRS_ST_FINISH;
    endcase
end

always @(posedge mclk_i)
begin
    if (rst_i || sysrst_w)
    begin
        state_q  <= `DRS_ST_IDLE;
        refresh_cycle_out_q <= 1'b0;
        ras_q    <= 1'b0;
        cas_q    <= 1'b0;
        inv_lo_q <= 1'b0;
        inv_hi_q <= 1'b0;
        ready_q  <= 1'b0;
        repeat_q <= 1'b0;
    end
    else if (step_w)
    begin
        state_q  <= state_d;
        refresh_cycle_out_q <= refresh_cycle_out_d;
        ras_q    <= ras_d;
        cas_q    <= cas_d;
        inv_lo_q <= inv_lo_d;
        inv_hi_q <= inv_hi_d;
        ready_q  <= ready_d;
        repeat_q <= repeat_d;
    end
end

// External counter clears its request on the refresh-cycle output
assign refresh_cycle_out_o    = refresh_cycle_out_q;
assign row_strobe_o           = ras_q;
assign column_strobe_enable_o = cas_q;
assign col_addr_invert_lo_o   = inv_lo_q;
assign col_addr_invert_hi_o   = inv_hi_q;
assign mem_cycle_ready_o      = ready_q;

endmodule // drs_sequencer

`default_nettype wire

// [testbench/drs_seq_checker.sv]
// Port assertions for the DRAM access and refresh sequencer.
// Assumes a phase A clock near 125 ns against a 10 ns mclk_i.
`timescale 1ns/10ps
`default_nettype none
module drs_seq_checker (
    input wire logic mclk_i,                 // Clock
    input wire logic rst_i,                  // Reset
    input wire logic phase_a_clock_i,        // Phase A
    input wire logic int_ack_active_i,       // Iack
    input wire logic system_reset_in_i,      // System reset
    input wire logic refresh_cycle_out_o,    // Refresh
    input wire logic row_strobe_o,           // Row
    input wire logic column_strobe_enable_o, // Column
    input wire logic col_addr_invert_lo_o,   // Count lo
    input wire logic col_addr_invert_hi_o,   // Count hi
    input wire logic mem_cycle_ready_o       // Ready
);
    logic       pa_q;
    logic [3:0] pa_cnt_q;
    wire  [1:0] cnt = {col_addr_invert_hi_o, col_addr_invert_lo_o};
    wire  [5:0] outs = {refresh_cycle_out_o, row_strobe_o,
                        column_strobe_enable_o, cnt, mem_cycle_ready_o};
    // Cycles since the phase A pin rose
    always_ff @(posedge mclk_i)
    begin
        pa_q <= phase_a_clock_i;
        if (rst_i || (phase_a_clock_i && !pa_q))
            pa_cnt_q <= 4'h0;
        else if (pa_cnt_q != 4'hf)
            pa_cnt_q <= pa_cnt_q + 4'h1;
    end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i || system_reset_in_i);
    chk_reset_clears:
    assert property (disable iff (1'b0) rst_i |=> outs == 6'h00)
        else $error("outputs not cleared by reset");
    chk_sysreset_idle:
    assert property (disable iff (rst_i)
        system_reset_in_i [*6] |=> outs == 6'h00)
        else $error("outputs not cleared by system reset");
    chk_step_timing:
    assert property ($changed(outs) |-> pa_cnt_q inside {[4'h1:4'h8]})
        else $error("output changed away from a phase A step");
    chk_refresh_start:
    assert property ($rose(refresh_cycle_out_o) |->
        column_strobe_enable_o && !row_strobe_o && !mem_cycle_ready_o)
        else $error("refresh start outputs wrong");
    chk_refresh_row:
    assert property ($rose(refresh_cycle_out_o) |->
        ##[10:16] (row_strobe_o && refresh_cycle_out_o))
        else $error("row strobe missing after refresh start");
    chk_refresh_finish:
    assert property ($fell(refresh_cycle_out_o) |->
        !row_strobe_o && !column_strobe_enable_o)
        else $error("refresh end left strobes high");
    chk_ready_cas:
    assert property ($rose(mem_cycle_ready_o) |-> row_strobe_o &&
        $past(column_strobe_enable_o) && !column_strobe_enable_o)
        else $error("ready without column drop");
    chk_count_step:
    assert property ($rose(mem_cycle_ready_o) |-> cnt == $past(cnt) + 2'h1)
        else $error("longword count did not advance by one");
    chk_iack_blocks:
    assert property (int_ack_active_i [*8] |->
        !($rose(row_strobe_o) && !refresh_cycle_out_o))
        else $error("access started during iack");
    cover property ($rose(refresh_cycle_out_o));
    cover property ($rose(mem_cycle_ready_o) && cnt == 2'h3);
    cover property ($fell(mem_cycle_ready_o) && column_strobe_enable_o);
endmodule // drs_seq_checker
bind drs_sequencer drs_seq_checker u_chk (.mclk_i, .rst_i,
    .phase_a_clock_i, .int_ack_active_i, .system_reset_in_i,
    .refresh_cycle_out_o, .row_strobe_o, .column_strobe_enable_o,
    .col_addr_invert_lo_o, .col_addr_invert_hi_o, .mem_cycle_ready_o);
`default_nettype wire

// [testbench/drs_refresh_model.sv]
// Refresh request counter at the sequencer's far side.
// Assumes a free-running phase A clock; counts only while enabled.
`timescale 1ns/10ps
`default_nettype none
module drs_refresh_model #(
    parameter int PERIOD = 6
) (
    input  wire logic phase_a_clock_i,     // Phase A
    input  wire logic enable_i,            // Count enable
    input  wire logic refresh_cycle_out_i, // Sequencer refresh
    output var  logic refresh_request_o    // Request out
);
    int cnt_q = 0;
    initial refresh_request_o = 1'b0;
    // Falling edge keeps the request clear of the step edge
    always @(negedge phase_a_clock_i)
    begin
        if (refresh_cycle_out_i)
        begin
            refresh_request_o <= 1'b0;
            cnt_q <= 0;
        end
        else if (enable_i && cnt_q == PERIOD)
            refresh_request_o <= 1'b1;
        else if (enable_i)
            cnt_q <= cnt_q + 1;
    end
endmodule // drs_refresh_model
`default_nettype wire

// [testbench/dram_access_refresh_sequencer_bench.sv]
// Self-checking bench for the DRAM access and refresh sequencer.
// Assumes the checker binds itself and the refresh model sits beside.
`timescale 1ns/10ps
`default_nettype none
`include "drs_defines.vh"
module dram_access_refresh_sequencer_bench;
    logic       mclk, rst, pa_clk, as, sel, iack, pwr, sysr, ds, wr, p4n;
    logic       rf_en, w;
    logic [1:0] typ, t;
    wire        refresh_request, refresh_cycle_out, ras, cas, inv_lo, inv_hi, rdy;
    wire  [5:0] outs = {refresh_cycle_out, ras, cas, inv_hi, inv_lo, rdy};
    int         bad_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         i;
    drs_sequencer dut (.mclk_i(mclk), .rst_i(rst), .phase_a_clock_i(pa_clk),
        .synced_addr_strobe_i(as), .dram_select_i(sel),
        .int_ack_active_i(iack), .refresh_request_i(refresh_request),
        .power_reset_i(pwr), .system_reset_in_i(sysr),
        .data_strobe_in_i(ds), .latched_write_i(wr), .phase_p4_low_i(p4n),
        .latched_address_i(typ), .refresh_cycle_out_o(refresh_cycle_out),
        .row_strobe_o(ras), .column_strobe_enable_o(cas),
        .col_addr_invert_lo_o(inv_lo), .col_addr_invert_hi_o(inv_hi),
        .mem_cycle_ready_o(rdy));
    drs_refresh_model #(.PERIOD(6)) u_refresh (.phase_a_clock_i(pa_clk),
        .enable_i(rf_en), .refresh_cycle_out_i(refresh_cycle_out),
        .refresh_request_o(refresh_request));
    function automatic logic [5:0] acc(input logic ca, input int k,
                                       input logic rd);
        return {1'b0, 1'b1, ca, 2'(k), rd};
    endfunction
    function automatic int blen(input logic [1:0] ty);
        return (ty == `DRS_TYPE_LONG) ? 1 : (ty == `DRS_TYPE_QUAD) ? 2 : 4;
    endfunction
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [5:0] exp, input logic [5:0] got,
                         input string nm);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One phase A step, then look and allow new inputs
    task automatic step(input logic [5:0] exp);
        @(posedge pa_clk);
        repeat (7) @(posedge mclk);
        @(negedge mclk);
        check(exp, outs, "outputs");
    endtask
    task automatic access(input logic [1:0] ty, input logic wt);
        int n;
        logic [5:0] e;
        n = blen(ty);
        {as, sel, wr, typ} = {2'h3, wt, ty};
        step(6'h10);
        ds = 1'b1;
        step(6'h18);
        for (int k = 1; k <= n; k++)
        begin
            p4n = 1'b0;
            step(acc(1'b0, k, 1'b1));
            p4n = 1'b1;
            if (k < n && wt)
            begin
                step(acc(1'b0, k, 1'b0));
                ds = 1'b0;
                step(acc(1'b0, k, 1'b0));
                ds = 1'b1;
                step(acc(1'b1, k, 1'b0));
            end
            else if (k < n)
            begin
                step(acc(1'b1, k, 1'b0));
                {p4n, ds} = 2'h1;
                step(acc(1'b1, k, 1'b0));
                ds = 1'b0;
            end
        end
        // Request held: done terms must end the burst by themselves
        repeat (2) step(6'h00);
        e = (ty == `DRS_TYPE_OCTA && !wt) ? 6'h00 : 6'h10;
        step(e);
        {as, sel, ds} = 3'h0;
        step(e);
        repeat (2) step(6'h00);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        pa_clk = 1'b0;
        #3;
        forever #62.5 pa_clk = ~pa_clk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            $display("[ERR] run expected end seen hang");
            stop_test();
        end
    end
    initial
    begin
        {as, sel, iack, pwr, sysr, ds, wr, rf_en, typ} = '0;
        rst = 1'b1;
        p4n = 1'b1;
        i = $urandom(17);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        step(6'h00);
        for (i = 0; i < 3; i++)
        begin
            {as, sel, iack} = {i != 0, i != 1, i == 2};
            repeat (2) step(6'h00);
        end
        {as, sel, iack} = 3'h0;
        step(6'h00);
        $display("test blocked done");
        {as, sel} = 2'h3;
        step(6'h10);
        {as, sel} = 2'h0;
        step(6'h10);
        repeat (2) step(6'h00);
        $display("test abort done");
        {as, sel, pwr} = 3'h7;
        repeat (2)
        begin
            step(6'h28);
            step(6'h38);
            step(6'h30);
            repeat (2) step(6'h00);
        end
        {as, sel, pwr} = 3'h0;
        step(6'h00);
        $display("test power done");
        rf_en = 1'b1;
        for (i = 0; i < 40 && refresh_request !== 1'b1; i++)
        begin
            @(negedge pa_clk);
            #1;
        end
        rf_en = 1'b0;
        step(6'h28);
        step(6'h38);
        step(6'h30);
        repeat (2) step(6'h00);
        check(6'h00, {5'h0, refresh_request}, "request");
        $display("test refresh done");
        {as, sel} = 2'h3;
        step(6'h10);
        ds = 1'b1;
        step(6'h18);
        sysr = 1'b1;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        check(6'h00, outs, "sysreset");
        {as, sel, ds, sysr} = 4'h0;
        repeat (2) step(6'h00);
        $display("test sysreset done");
        for (i = 0; i < 12; i++)
        begin
            t = (i < 8) ? 2'(i) : 2'($urandom_range(3));
            w = (i < 8) ? i[2] : 1'($urandom_range(1));
            access(t, w);
            repeat ($urandom_range(2)) step(6'h00);
        end
        $display("test bursts done");
        stop_test();
    end
endmodule // dram_access_refresh_sequencer_bench
`default_nettype wire
